// ==== pkg/dimc_pkg.sv ====
// Package with register map, field positions, codes and timing for the block.
package dimc_pkg;
	// -------------------------------------------------------------------
	// Register offsets
	// -------------------------------------------------------------------
	localparam logic [7:0] ADDR_SLOT_A_INTEGRATOR_SETUP = 8'h42;
	localparam logic [7:0] ADDR_SLOT_A_FRONTEND_CONNECTION = 8'h43;
	localparam logic [7:0] ADDR_SLOT_B_INTEGRATOR_SETUP = 8'h44;
	localparam logic [7:0] ADDR_SLOT_B_FRONTEND_CONNECTION = 8'h45;
	localparam logic [7:0] ADDR_CONVERTER_TIMING = 8'h4e;
	localparam logic [7:0] ADDR_INTEGRATE_ENABLE_BITS = 8'h58;
	localparam logic [7:0] ADDR_INTEGRATION_SETUP_WORD = 8'h5a;
	// -------------------------------------------------------------------
	// Reset values
	// -------------------------------------------------------------------
	localparam logic [15:0] RST_INTEGRATOR_SETUP = 16'h1c00;
	localparam logic [15:0] RST_FRONTEND_CONNECTION = 16'hada5;
	localparam logic [15:0] RST_CONVERTER_TIMING = 16'h0000;
	localparam logic [15:0] RST_INTEGRATE_ENABLE_BITS = 16'h0000;
	localparam logic [15:0] RST_INTEGRATION_SETUP_WORD = 16'h0000;
	// -------------------------------------------------------------------
	// Field positions and codes
	// -------------------------------------------------------------------
	localparam int MODE_FIELD_LSB = 8;
	localparam int SLOT_A_ENABLE_BIT = 12;
	localparam int SLOT_B_ENABLE_BIT = 13;
	localparam int SLOT_A_SINGLE_PAIR_BIT = 5;
	localparam int SLOT_B_SINGLE_PAIR_BIT = 6;
	localparam logic [7:0] MODE_NORMAL_INTEGRATOR = 8'h1c;
	localparam logic [7:0] MODE_VOLTAGE_BUFFER = 8'h1d;
	localparam logic [15:0] CONN_NORMAL_PATH = 16'hada5;
	localparam logic [15:0] CONN_BYPASS_FILTER = 16'hae65;
	localparam logic [15:0] CONN_BYPASS_BOTH = 16'hb065;
	localparam logic [15:0] TIMING_DIRECT_1MHZ = 16'h0040;
	localparam logic [13:0] SATURATION_LIMIT = 14'h3fff;
	// -------------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int CONVERSION_PERIOD_NS = 1000;
	localparam int CONV_CYCLES_INT = CONVERSION_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [4:0] CONV_CYCLES = 5'(CONV_CYCLES_INT);
	localparam logic [4:0] CONV_HALF = 5'(CONV_CYCLES_INT / 2);

	typedef enum logic [1:0] {
		PATH_NORMAL = 2'b00,
		PATH_NO_FILTER = 2'b01,
		PATH_DIRECT = 2'b10,
		PATH_OTHER = 2'b11
	} dimc_path_t;
endpackage

// ==== rtl/dimc_slot_decode.sv ====
// Per-slot decode of the front-end and integrate settings.
`timescale 1ns/1ps
module dimc_slot_decode
	import dimc_pkg::*;
(
	input wire logic [15:0] mode_word_i,
	input wire logic [15:0] conn_word_i,
	input wire logic integrate_en_i,
	input wire logic single_pair_i,
	output logic integrator_buffer_o,
	output logic filter_bypass_o,
	output logic integrator_bypass_o,
	output logic direct_mode_o,
	output logic integrate_mode_o,
	output logic single_pair_o
);
	logic [7:0] mode_field;
	dimc_path_t path;

	function automatic dimc_path_t decode_path(input logic [15:0] w);
		case (w)
			CONN_NORMAL_PATH: decode_path = PATH_NORMAL;
			CONN_BYPASS_FILTER: decode_path = PATH_NO_FILTER;
			CONN_BYPASS_BOTH: decode_path = PATH_DIRECT;
			default: decode_path = PATH_OTHER;
		endcase
	endfunction

	always_comb begin
		mode_field = mode_word_i[MODE_FIELD_LSB +: 8];
		path = decode_path(conn_word_i);
		filter_bypass_o = (path == PATH_NO_FILTER) || (path == PATH_DIRECT);
		integrator_bypass_o = (path == PATH_DIRECT);
		direct_mode_o = (path == PATH_DIRECT) && !integrate_en_i;
		integrate_mode_o = integrate_en_i;
		// Buffer only when not in direct mode, where the field is moot.
		integrator_buffer_o = !direct_mode_o &&
			(mode_field == MODE_VOLTAGE_BUFFER);
		// Pair selection matters only while integrating.
		single_pair_o = integrate_en_i && single_pair_i;
	end
endmodule

// ==== rtl/dimc_config_bank.sv ====
// Configuration register bank for normal, direct and digital integrate modes.
`timescale 1ns/1ps
module dimc_config_bank
	import dimc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic slot_b_active_i,
	input wire logic window_active_i,
	output logic [15:0] reg_rdata_o,
	output logic reg_rvalid_o,
	output logic integrator_buffer_o,
	output logic filter_bypass_o,
	output logic integrator_bypass_o,
	output logic direct_mode_o,
	output logic integrate_mode_o,
	output logic single_pair_o,
	output logic gapped_timing_o,
	output logic conv_clk_o,
	output logic conv_strobe_o
);
	// -------------------------------------------------------------------
	// Register storage
	// -------------------------------------------------------------------
	logic [15:0] a_mode_ff, nxt_a_mode;
	logic [15:0] a_conn_ff, nxt_a_conn;
	logic [15:0] b_mode_ff, nxt_b_mode;
	logic [15:0] b_conn_ff, nxt_b_conn;
	logic [15:0] timing_ff, nxt_timing;
	logic [15:0] enable_ff, nxt_enable;
	logic [15:0] setup_ff, nxt_setup;
	logic [15:0] rdata_ff, nxt_rdata;
	logic rvalid_ff, nxt_rvalid;
	logic [6:0] wr_sel, rd_sel;

	// -------------------------------------------------------------------
	// Address decode
	// -------------------------------------------------------------------
	// One select bit per mapped register; unmapped addresses select none.
	function automatic logic [6:0] reg_select(input logic [7:0] a);
		logic [6:0] s;
		s = 7'h00;
		case (a)
			ADDR_SLOT_A_INTEGRATOR_SETUP: s[0] = 1'b1;
			ADDR_SLOT_A_FRONTEND_CONNECTION: s[1] = 1'b1;
			ADDR_SLOT_B_INTEGRATOR_SETUP: s[2] = 1'b1;
			ADDR_SLOT_B_FRONTEND_CONNECTION: s[3] = 1'b1;
			ADDR_CONVERTER_TIMING: s[4] = 1'b1;
			ADDR_INTEGRATE_ENABLE_BITS: s[5] = 1'b1;
			ADDR_INTEGRATION_SETUP_WORD: s[6] = 1'b1;
			default: s = 7'h00;
		endcase
		return s;
	endfunction

	// -------------------------------------------------------------------
	// Register write and read
	// -------------------------------------------------------------------
	always_comb begin
		wr_sel = reg_wr_i ? reg_select(reg_addr_i) : 7'h00;
		rd_sel = reg_rd_i ? reg_select(reg_addr_i) : 7'h00;
		// Writes to unmapped addresses leave every register unchanged.
		nxt_a_mode = wr_sel[0] ? reg_wdata_i : a_mode_ff;
		nxt_a_conn = wr_sel[1] ? reg_wdata_i : a_conn_ff;
		nxt_b_mode = wr_sel[2] ? reg_wdata_i : b_mode_ff;
		nxt_b_conn = wr_sel[3] ? reg_wdata_i : b_conn_ff;
		nxt_timing = wr_sel[4] ? reg_wdata_i : timing_ff;
		nxt_enable = wr_sel[5] ? reg_wdata_i : enable_ff;
		nxt_setup = wr_sel[6] ? reg_wdata_i : setup_ff;
		// A read sees the value held before a write in the same cycle.
		nxt_rvalid = reg_rd_i;
		nxt_rdata = 16'h0000;
		if (rd_sel[0]) nxt_rdata = a_mode_ff;
		if (rd_sel[1]) nxt_rdata = a_conn_ff;
		if (rd_sel[2]) nxt_rdata = b_mode_ff;
		if (rd_sel[3]) nxt_rdata = b_conn_ff;
		if (rd_sel[4]) nxt_rdata = timing_ff;
		if (rd_sel[5]) nxt_rdata = enable_ff;
		if (rd_sel[6]) nxt_rdata = setup_ff;
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			a_mode_ff <= RST_INTEGRATOR_SETUP;
			a_conn_ff <= RST_FRONTEND_CONNECTION;
			b_mode_ff <= RST_INTEGRATOR_SETUP;
			b_conn_ff <= RST_FRONTEND_CONNECTION;
			timing_ff <= RST_CONVERTER_TIMING;
			enable_ff <= RST_INTEGRATE_ENABLE_BITS;
			setup_ff <= RST_INTEGRATION_SETUP_WORD;
			rdata_ff <= 16'h0000;
			rvalid_ff <= 1'b0;
		end else begin
			a_mode_ff <= nxt_a_mode;
			a_conn_ff <= nxt_a_conn;
			b_mode_ff <= nxt_b_mode;
			b_conn_ff <= nxt_b_conn;
			timing_ff <= nxt_timing;
			enable_ff <= nxt_enable;
			setup_ff <= nxt_setup;
			rdata_ff <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	// -------------------------------------------------------------------
	// Per-slot decode
	// -------------------------------------------------------------------
	logic [5:0] dec [2];
	logic [15:0] sel_mode [2];
	logic [15:0] sel_conn [2];
	logic sel_en [2];
	logic sel_single [2];

	always_comb begin
		sel_mode[0] = a_mode_ff;
		sel_mode[1] = b_mode_ff;
		sel_conn[0] = a_conn_ff;
		sel_conn[1] = b_conn_ff;
		sel_en[0] = enable_ff[SLOT_A_ENABLE_BIT];
		sel_en[1] = enable_ff[SLOT_B_ENABLE_BIT];
		sel_single[0] = setup_ff[SLOT_A_SINGLE_PAIR_BIT];
		sel_single[1] = setup_ff[SLOT_B_SINGLE_PAIR_BIT];
	end

	// Both slots are decoded at all times; the active one is picked below.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_slot
			dimc_slot_decode u_dec (
				.mode_word_i(sel_mode[gi]),
				.conn_word_i(sel_conn[gi]),
				.integrate_en_i(sel_en[gi]),
				.single_pair_i(sel_single[gi]),
				.integrator_buffer_o(dec[gi][0]),
				.filter_bypass_o(dec[gi][1]),
				.integrator_bypass_o(dec[gi][2]),
				.direct_mode_o(dec[gi][3]),
				.integrate_mode_o(dec[gi][4]),
				.single_pair_o(dec[gi][5])
			);
		end
	endgenerate

	// -------------------------------------------------------------------
	// Active slot outputs and converter timing
	// -------------------------------------------------------------------
	logic [5:0] out_ff, nxt_out;
	logic gap_ff, nxt_gap;
	logic [4:0] cnt_ff, nxt_cnt;
	logic cclk_ff, nxt_cclk;
	logic strobe_ff, nxt_strobe;
	logic run_conv;

	// The counter restarts whenever the run condition drops, so every run
	// opens with a strobe and a full high phase of the converter clock.
	always_comb begin
		nxt_out = slot_b_active_i ? dec[1] : dec[0];
		// Gapped timing bit is moot outside integrate mode.
		nxt_gap = nxt_out[4] && setup_ff[7];
		run_conv = (nxt_out[3] && timing_ff == TIMING_DIRECT_1MHZ) ||
			(nxt_out[4] && window_active_i);
		nxt_cnt = 5'h00;
		nxt_cclk = 1'b0;
		nxt_strobe = 1'b0;
		if (run_conv) begin
			nxt_cnt = (cnt_ff == CONV_CYCLES - 5'h01) ? 5'h00 : cnt_ff + 5'h01;
			nxt_cclk = (cnt_ff < CONV_HALF);
			nxt_strobe = (cnt_ff == 5'h00);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			out_ff <= 6'h00;
			gap_ff <= 1'b0;
			cnt_ff <= 5'h00;
			cclk_ff <= 1'b0;
			strobe_ff <= 1'b0;
		end else begin
			out_ff <= nxt_out;
			gap_ff <= nxt_gap;
			cnt_ff <= nxt_cnt;
			cclk_ff <= nxt_cclk;
			strobe_ff <= nxt_strobe;
		end
	end

	// -------------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------------
	assign reg_rdata_o = rdata_ff;
	assign reg_rvalid_o = rvalid_ff;
	assign integrator_buffer_o = out_ff[0];
	assign filter_bypass_o = out_ff[1];
	assign integrator_bypass_o = out_ff[2];
	assign direct_mode_o = out_ff[3];
	assign integrate_mode_o = out_ff[4];
	assign single_pair_o = out_ff[5];
	assign gapped_timing_o = gap_ff;
	assign conv_clk_o = cclk_ff;
	assign conv_strobe_o = strobe_ff;
endmodule

// ==== tb/dimc_cfg_properties.sv ====
// Concurrent properties watching the configuration bank ports.
`timescale 1ns/1ps
module dimc_cfg_properties (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	input wire logic integrator_buffer_o,
	input wire logic filter_bypass_o,
	input wire logic integrator_bypass_o,
	input wire logic direct_mode_o,
	input wire logic integrate_mode_o,
	input wire logic single_pair_o,
	input wire logic gapped_timing_o,
	input wire logic conv_clk_o,
	input wire logic conv_strobe_o
);
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_clk_high; conv_clk_o [*8]; endsequence
	sequence s_quiet; !conv_strobe_o [*8]; endsequence
	property p_rd; reg_rd_i |=> reg_rvalid_o; endproperty
	property p_idle; !reg_rvalid_o |-> reg_rdata_o == 16'h0000; endproperty
	property p_byp; integrator_bypass_o |-> filter_bypass_o; endproperty
	property p_dir; direct_mode_o |-> !integrate_mode_o; endproperty
	property p_buf; integrator_buffer_o |-> !direct_mode_o; endproperty
	property p_sub; single_pair_o || gapped_timing_o |-> integrate_mode_o;
	endproperty
	property p_hi; conv_strobe_o |-> s_clk_high; endproperty
	property p_per; conv_strobe_o |=> s_quiet; endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	a_idle: assert property (p_idle) else $error("read data not zero");
	a_byp: assert property (p_byp) else $error("bypass mismatch");
	a_dir: assert property (p_dir) else $error("direct mode wrong");
	a_buf: assert property (p_buf) else $error("buffer in direct");
	a_sub: assert property (p_sub) else $error("setup word used");
	a_hi: assert property (p_hi) else $error("clock high too short");
	a_per: assert property (p_per) else $error("strobe too soon");
endmodule
bind dimc_config_bank dimc_cfg_properties u_dimc_cfg_properties (
	.core_clk_i, .rst_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o,
	.integrator_buffer_o, .filter_bypass_o, .integrator_bypass_o,
	.direct_mode_o, .integrate_mode_o, .single_pair_o, .gapped_timing_o,
	.conv_clk_o, .conv_strobe_o);

// ==== tb/dimc_optical_model.sv ====
// Model of the optical path that selects the slot and frames windows.
`timescale 1ns/1ps
module dimc_optical_model (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic slot_b_i,
	input wire logic start_i,
	input wire logic [7:0] win_len_i,
	output logic slot_b_active_o,
	output logic window_active_o
);
	logic [7:0] left_ff;
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			left_ff <= 8'h00;
			slot_b_active_o <= 1'b0;
		end else begin
			left_ff <= start_i ? win_len_i : left_ff - 8'(left_ff != 8'h00);
			slot_b_active_o <= slot_b_i;
		end
	end
	assign window_active_o = left_ff != 8'h00;
endmodule

// ==== tb/dimc_config_bank_tb.sv ====
// Self-checking bench for the digital integrate configuration bank.
`timescale 1ns/1ps
module dimc_config_bank_tb;
	import dimc_pkg::*;
	localparam int RUN = 190;
	localparam int NSTB = (RUN + CONV_CYCLES_INT - 1) / CONV_CYCLES_INT;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic slot_b = 1'b0;
	logic start = 1'b0;
	logic slot_b_active_i, window_active_i, reg_rvalid_o, conv_clk_o;
	logic integrator_buffer_o, filter_bypass_o, integrator_bypass_o;
	logic direct_mode_o, integrate_mode_o, single_pair_o, gapped_timing_o;
	logic conv_strobe_o;
	logic [15:0] reg_rdata_o, e;
	logic sat_seen;
	int error_cnt = 0;
	int n_compared = 0;
	logic [7:0] adr [8] = '{ADDR_SLOT_A_INTEGRATOR_SETUP,
		ADDR_SLOT_A_FRONTEND_CONNECTION, ADDR_SLOT_B_INTEGRATOR_SETUP,
		ADDR_SLOT_B_FRONTEND_CONNECTION, ADDR_CONVERTER_TIMING,
		ADDR_INTEGRATE_ENABLE_BITS, ADDR_INTEGRATION_SETUP_WORD, 8'h50};
	logic [15:0] rv [8] = '{RST_INTEGRATOR_SETUP, RST_FRONTEND_CONNECTION,
		RST_INTEGRATOR_SETUP, RST_FRONTEND_CONNECTION, RST_CONVERTER_TIMING,
		RST_INTEGRATE_ENABLE_BITS, RST_INTEGRATION_SETUP_WORD, 16'h0000};
	logic [15:0] conns [3] = '{CONN_NORMAL_PATH, CONN_BYPASS_FILTER,
		CONN_BYPASS_BOTH};
	wire [15:0] modes = {9'h000, integrator_buffer_o, filter_bypass_o,
		integrator_bypass_o, direct_mode_o, integrate_mode_o, single_pair_o,
		gapped_timing_o};
	always #25 core_clk_i = ~core_clk_i;
	dimc_config_bank u_dimc_config_bank (.core_clk_i, .rst_i, .reg_addr_i,
		.reg_wr_i, .reg_rd_i, .reg_wdata_i, .slot_b_active_i, .window_active_i,
		.reg_rdata_o, .reg_rvalid_o, .integrator_buffer_o, .filter_bypass_o,
		.integrator_bypass_o, .direct_mode_o, .integrate_mode_o,
		.single_pair_o, .gapped_timing_o, .conv_clk_o, .conv_strobe_o);
	dimc_optical_model u_dimc_optical_model (.core_clk_i, .rst_i,
		.slot_b_i(slot_b), .start_i(start), .win_len_i(8'(RUN)),
		.slot_b_active_o(slot_b_active_i), .window_active_o(window_active_i));
	task automatic tick(int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic chk(string what, logic [15:0] x, logic [15:0] s);
		n_compared++;
		if (s !== x) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, x, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [15:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		tick(1);
		reg_wr_i = 1'b0;
		tick(1);
	endtask
	task automatic rd(logic [7:0] a, logic [15:0] x);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		tick(1);
		reg_rd_i = 1'b0;
		chk("rvalid", 16'h0001, {15'h0000, reg_rvalid_o});
		chk("rdata", x, reg_rdata_o);
		tick(1);
	endtask
	// Strobes are sampled once per cycle, so none can slip past.
	task automatic count(int n, int x);
		logic [15:0] k;
		logic [15:0] h;
		k = 16'h0000;
		h = 16'h0000;
		repeat (n) begin
			k += {15'h0000, conv_strobe_o};
			h += {15'h0000, conv_clk_o};
			tick(1);
		end
		chk("strobes", 16'(x), k);
		chk("clock high", 16'(x * (CONV_CYCLES_INT / 2)), h);
	endtask
	// Software-side saturation test on one slot's signal and dark sums.
	function automatic logic sat_flag(int sig, int dark, int led_w,
		int win_w, int pulses, logic single);
		int w;
		w = single ? win_w : 2 * win_w;
		return (sig / (led_w < w ? led_w : w) + dark / w) / pulses >
			int'(SATURATION_LIMIT);
	endfunction
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		tick(5000);
		error_cnt++;
		complete_run();
	end
	initial begin
		tick(12);
		rst_i = 1'b0;
		chk("modes", 16'h0000, modes);
		foreach (adr[i]) rd(adr[i], rv[i]);
		$display("test reset values done");
		foreach (adr[i]) wr(adr[i], {adr[i], ~adr[i]});
		foreach (adr[i]) rd(adr[i], i < 7 ? {adr[i], ~adr[i]} : 16'h0000);
		$display("test readback done");
		wr(ADDR_INTEGRATE_ENABLE_BITS, 16'h0000);
		wr(ADDR_SLOT_A_INTEGRATOR_SETUP, {MODE_VOLTAGE_BUFFER, 8'h00});
		foreach (conns[i]) begin
			wr(ADDR_SLOT_A_FRONTEND_CONNECTION, conns[i]);
			e = {9'h000, i != 2, i != 0, i == 2, i == 2, 3'b000};
			chk("modes", e, modes);
		end
		wr(ADDR_CONVERTER_TIMING, TIMING_DIRECT_1MHZ);
		count(RUN, NSTB);
		wr(ADDR_CONVERTER_TIMING, 16'h0041);
		count(60, 0);
		$display("test path and direct conversion done");
		wr(ADDR_SLOT_A_INTEGRATOR_SETUP, {MODE_NORMAL_INTEGRATOR, 8'h00});
		wr(ADDR_SLOT_A_FRONTEND_CONNECTION, CONN_NORMAL_PATH);
		wr(ADDR_INTEGRATE_ENABLE_BITS, 16'h1000);
		wr(ADDR_INTEGRATION_SETUP_WORD, 16'h00a0);
		chk("modes", 16'h0007, modes);
		start = 1'b1;
		tick(1);
		start = 1'b0;
		count(RUN + 30, NSTB);
		slot_b = 1'b1;
		tick(3);
		chk("modes", 16'h0000, modes);
		wr(ADDR_INTEGRATE_ENABLE_BITS, 16'h2000);
		chk("modes", 16'h0005, modes);
		wr(ADDR_INTEGRATION_SETUP_WORD, 16'h0040);
		chk("modes", 16'h0006, modes);
		wr(ADDR_INTEGRATION_SETUP_WORD, 16'h0000);
		chk("modes", 16'h0004, modes);
		$display("test digital integrate done");
		sat_seen = sat_flag(32766, 4, 2, 4, 1, 1'b1);
		chk("sat single", 16'h0001, {15'h0000, sat_seen});
		sat_seen = sat_flag(32766, 4, 2, 4, 1, 1'b0);
		chk("sat double", 16'h0000, {15'h0000, sat_seen});
		$display("test saturation arithmetic done");
		complete_run();
	end
endmodule
